// File: bench/eeprom_access_ctrl_tb_top.sv
// self-checking bench for the store access controller
`timescale 1ns/1ps
`include "nvm_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end

module eeprom_access_ctrl_tb_top;
  logic REF_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic DONE_CLR = 1'b0;
  nvm_pkg::sfr_req_s req = '0;
  logic [7:0] rdata;
  logic done;
  int err_count = 0;
  int n_tests = 0;
  int ones;
  logic [7:0] mem [64];
  logic [7:0] v;
  logic [5:0] a;
  logic [5:0] q[$];

  eeprom_access_ctrl #(.WRITE_CYCLES(8)) dut_u (
    .REF_CLK(REF_CLK),
    .RESETN(RESETN),
    .SFR_REQ(req),
    .SFR_RDATA(rdata),
    .DONE_FLAG(done),
    .DONE_CLR(DONE_CLR)
  );

  initial begin
    forever #12.5 REF_CLK = ~REF_CLK;
  end

  // ---------------------------------------------------------------
  // bus tasks and end-of-test report
  // ---------------------------------------------------------------
  // one access, then an idle edge so the request never changes twice in a step
  task automatic acc(input logic bk, input logic [7:0] ad, input logic w, input logic [7:0] d);
    req = '{bank: bk, addr: ad, we: w, re: !w, wdata: d};
    @(posedge REF_CLK);
    #1;
    v = rdata;
    req = '0;
    @(posedge REF_CLK);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // bounded poll of a start bit; counts reads that still saw it set
  task automatic poll(input int bitn);
    int i;
    ones = 0;
    for (i = 0; i < 40; i++) begin
      acc(`NVM_CTRL_BANK, `NVM_CTRL_OFS, 1'b0, 8'h00);
      if (v[bitn] === 1'b0) break;
      ones++;
    end
    if (i == 40) begin
      err_count++;
      $display("ERROR %0t start bit never cleared", $time);
      stop_test();
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hD902));
    repeat (20) @(posedge REF_CLK);
    #1;
    RESETN = 1'b1;
    acc(`NVM_CTRL_BANK, `NVM_CTRL_OFS, 1'b0, 8'h00);
    `CHK(v, 8'h00)
    acc(1'b0, 8'h33, 1'b0, 8'h00);
    `CHK(v, 8'h00)
    acc(`NVM_CTRL_BANK, `NVM_CTRL_OFS, 1'b1, 8'h04);
    acc(`NVM_CTRL_BANK, `NVM_CTRL_OFS, 1'b1, 8'h01);
    // control offset in the wrong bank must not reach the control register
    acc(`NVM_ADDR_BANK, `NVM_CTRL_OFS, 1'b1, 8'h0A);
    acc(`NVM_CTRL_BANK, `NVM_CTRL_OFS, 1'b0, 8'h00);
    `CHK(v, 8'h00)
    acc(`NVM_ADDR_BANK, `NVM_ADDR_OFS, 1'b1, 8'hFF);
    acc(`NVM_ADDR_BANK, `NVM_ADDR_OFS, 1'b0, 8'h00);
    `CHK(v, 8'h3F)
    for (int k = 0; k < 4; k++) begin
      a = 6'($urandom);
      mem[a] = 8'($urandom);
      q.push_back(a);
      acc(`NVM_ADDR_BANK, `NVM_ADDR_OFS, 1'b1, {2'h0, a});
      acc(`NVM_ADDR_BANK, `NVM_DATA_OFS, 1'b1, mem[a]);
      acc(`NVM_CTRL_BANK, `NVM_CTRL_OFS, 1'b1, 8'h08);
      acc(`NVM_CTRL_BANK, `NVM_CTRL_OFS, 1'b1, 8'h0C);
      // a read start while busy must be dropped, enables still land
      acc(`NVM_CTRL_BANK, `NVM_CTRL_OFS, 1'b1, 8'h0B);
      acc(`NVM_CTRL_BANK, `NVM_CTRL_OFS, 1'b0, 8'h00);
      `CHK(v, 8'h0E)
      poll(`NVM_WR_BIT);
      `CHK(v, 8'h0A)
      `CHK(done, 1'b1)
      DONE_CLR = 1'b1;
      @(posedge REF_CLK);
      #1;
      DONE_CLR = 1'b0;
      `CHK(done, 1'b0)
    end
    foreach (q[i]) begin
      acc(`NVM_ADDR_BANK, `NVM_ADDR_OFS, 1'b1, {2'h0, q[i]});
      acc(`NVM_CTRL_BANK, `NVM_CTRL_OFS, 1'b1, 8'h02);
      acc(`NVM_CTRL_BANK, `NVM_CTRL_OFS, 1'b1, 8'h03);
      poll(`NVM_RD_BIT);
      `CHK(ones > 0, 1'b1)
      `CHK(done, 1'b1)
      DONE_CLR = 1'b1;
      @(posedge REF_CLK);
      #1;
      DONE_CLR = 1'b0;
      `CHK(done, 1'b0)
      acc(`NVM_ADDR_BANK, `NVM_DATA_OFS, 1'b0, 8'h00);
      `CHK(v, mem[q[i]])
      acc(`NVM_ADDR_BANK, `NVM_ADDR_OFS, 1'b1, 8'h00);
      acc(`NVM_ADDR_BANK, `NVM_DATA_OFS, 1'b0, 8'h00);
      `CHK(v, mem[q[i]])
    end
    stop_test();
  end
endmodule

// File: core/eeprom_access_ctrl.sv
// register-driven controller for a 64 x 8 non-volatile data store
`timescale 1ns/1ps
`include "nvm_defs.svh"

module eeprom_access_ctrl #(
  parameter int WRITE_CYCLES =
    (`NVM_WRITE_TIME_US * 1000 + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire nvm_pkg::sfr_req_s SFR_REQ,
  output logic [7:0] SFR_RDATA,
  output logic DONE_FLAG,
  input wire logic DONE_CLR
);

  // ---------------------------------------------------------------
  // state and storage
  // ---------------------------------------------------------------
  nvm_pkg::ctrl_state_s s_reg;
  nvm_pkg::ctrl_state_s s_next;
  logic [7:0] mem [0:`NVM_DEPTH-1];
  logic [16:0] wr_last;
  logic [16:0] rd_last;
  logic busy;
  logic end_w;
  logic end_r;
  logic sel_addr;
  logic sel_data;
  logic sel_ctrl;
  logic start_w;
  logic start_r;

  assign wr_last = 17'(WRITE_CYCLES - 1);
  assign rd_last = 17'(`NVM_READ_CYCLES - 1);
  assign busy = s_reg.wr | s_reg.rd;
  assign end_w = s_reg.wr && s_reg.cnt == wr_last;
  assign end_r = s_reg.rd && s_reg.cnt == rd_last;
  // control only answers in bank 1, so a stale bank 0 pointer cannot hit it
  assign sel_addr = SFR_REQ.bank == `NVM_ADDR_BANK && SFR_REQ.addr == `NVM_ADDR_OFS;
  assign sel_data = SFR_REQ.bank == `NVM_ADDR_BANK && SFR_REQ.addr == `NVM_DATA_OFS;
  assign sel_ctrl = SFR_REQ.bank == `NVM_CTRL_BANK && SFR_REQ.addr == `NVM_CTRL_OFS;
  // enable must already be set: same-write enable and start is refused
  assign start_w = SFR_REQ.we && sel_ctrl && !busy && SFR_REQ.wdata[`NVM_WR_BIT]
                   && s_reg.write_enable_gate;
  assign start_r = SFR_REQ.we && sel_ctrl && !busy && !start_w && SFR_REQ.wdata[`NVM_RD_BIT]
                   && s_reg.read_enable_gate;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (SFR_REQ.we && sel_addr) begin
      s_next.addr = SFR_REQ.wdata[5:0];
    end
    if (SFR_REQ.we && sel_data) begin
      s_next.data = SFR_REQ.wdata;
    end
    if (SFR_REQ.we && sel_ctrl) begin
      s_next.write_enable_gate = SFR_REQ.wdata[`NVM_WRITE_GATE_BIT];
      s_next.read_enable_gate = SFR_REQ.wdata[`NVM_READ_GATE_BIT];
    end
    if (busy) begin
      s_next.cnt = s_reg.cnt + 17'h00001;
    end
    if (start_w) begin
      s_next.wr = 1'b1;
      s_next.cnt = 17'h00000;
      s_next.lat_addr = s_reg.addr;
      s_next.lat_data = s_reg.data;
    end
    if (start_r) begin
      s_next.rd = 1'b1;
      s_next.cnt = 17'h00000;
    end
    if (end_w) begin
      s_next.wr = 1'b0;
      s_next.cnt = 17'h00000;
    end
    // a read end overrides a same-cycle software write of the data register
    if (end_r) begin
      s_next.rd = 1'b0;
      s_next.cnt = 17'h00000;
      s_next.data = mem[s_reg.addr];
    end
    // set wins over a clear in the same cycle
    if (DONE_CLR) begin
      s_next.done = 1'b0;
    end
    if (end_w || end_r) begin
      s_next.done = 1'b1;
    end
    s_next.rdata = 8'h00;
    if (SFR_REQ.re && sel_addr) begin
      s_next.rdata = {2'h0, s_reg.addr};
    end else if (SFR_REQ.re && sel_data) begin
      s_next.rdata = s_reg.data;
    end else if (SFR_REQ.re && sel_ctrl) begin
      s_next.rdata = {4'h0, s_reg.write_enable_gate, s_reg.wr, s_reg.read_enable_gate,
                      s_reg.rd};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      s_reg <= '0;
      s_reg.addr <= `NVM_ADDR_RESET;
      s_reg.data <= `NVM_DATA_RESET;
      {s_reg.write_enable_gate, s_reg.wr, s_reg.read_enable_gate, s_reg.rd} <=
        `NVM_CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // contents survive reset, as a non-volatile array would
  always_ff @(posedge REF_CLK) begin
    if (RESETN && end_w) begin
      mem[s_reg.lat_addr] <= s_reg.lat_data;
    end
  end

  assign SFR_RDATA = s_reg.rdata;
  assign DONE_FLAG = s_reg.done;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  property p_addr_upper;
    SFR_REQ.re && sel_addr |=> SFR_RDATA[7:6] == 2'h0;
  endproperty
  a_addr_upper: assert property (p_addr_upper) else $error("address upper bits not zero");

  property p_ctrl_upper;
    SFR_REQ.re && sel_ctrl |=> SFR_RDATA[7:4] == 4'h0 && SFR_RDATA[2] == $past(s_reg.wr);
  endproperty
  a_ctrl_upper: assert property (p_ctrl_upper) else $error("control readback wrong");

  property p_wr_gated;
    SFR_REQ.we && sel_ctrl && SFR_REQ.wdata[`NVM_WR_BIT] && !s_reg.write_enable_gate && !busy
      |=> !s_reg.wr;
  endproperty
  a_wr_gated: assert property (p_wr_gated) else $error("write began without enable");

  property p_rd_gated;
    SFR_REQ.we && sel_ctrl && SFR_REQ.wdata[`NVM_RD_BIT] && !s_reg.read_enable_gate && !busy
      |=> !s_reg.rd;
  endproperty
  a_rd_gated: assert property (p_rd_gated) else $error("read began without enable");

  property p_rd_length;
    $rose(s_reg.rd) |-> s_reg.rd [*2] ##1 !s_reg.rd;
  endproperty
  a_rd_length: assert property (p_rd_length) else $error("read cycle length wrong");

  property p_rd_data;
    $fell(s_reg.rd) |-> s_reg.data == mem[$past(s_reg.addr)];
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data not loaded");

  property p_wr_hold;
    s_reg.wr && s_reg.cnt < wr_last |=> s_reg.wr && s_reg.cnt == $past(s_reg.cnt) + 17'h00001;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write start dropped early");

  property p_done_set;
    end_w || end_r |=> DONE_FLAG && !busy;
  endproperty
  a_done_set: assert property (p_done_set) else $error("completion flag not set");

  property p_data_keep;
    !s_reg.rd && !(SFR_REQ.we && sel_data) |=> s_reg.data == $past(s_reg.data);
  endproperty
  a_data_keep: assert property (p_data_keep) else $error("data register changed");

  property p_no_overlap;
    s_reg.wr && SFR_REQ.we && sel_ctrl |=> !s_reg.rd;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("read began during write");

  // checked through reset itself, so the default disable is overridden
  property p_reset_clear;
    disable iff (1'b0)
    !RESETN |=> {s_reg.write_enable_gate, s_reg.wr, s_reg.read_enable_gate, s_reg.rd}
      == `NVM_CTRL_RESET && !DONE_FLAG && SFR_RDATA == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("control not cleared by reset");

  property p_cov_write;
    start_w ##1 s_reg.wr;
  endproperty
  c_cov_write: cover property (p_cov_write);
  property p_cov_read;
    start_r ##3 !s_reg.rd;
  endproperty
  c_cov_read: cover property (p_cov_read);
  property p_cov_refused;
    SFR_REQ.we && sel_ctrl && SFR_REQ.wdata[`NVM_WR_BIT] && !s_reg.write_enable_gate;
  endproperty
  c_cov_refused: cover property (p_cov_refused);
  property p_cov_busy_read;
    s_reg.wr && SFR_REQ.we && sel_ctrl && SFR_REQ.wdata[`NVM_RD_BIT];
  endproperty
  c_cov_busy_read: cover property (p_cov_busy_read);

endmodule

// File: shared/nvm_defs.svh
// offsets, field positions, reset values and timing counts of the store access block
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define NVM_ADDR_OFS 8'h1E
`define NVM_DATA_OFS 8'h1F
`define NVM_CTRL_OFS 8'h40
`define NVM_ADDR_BANK 1'h0
`define NVM_CTRL_BANK 1'h1

// ---------------------------------------------------------------
// control fields and reset values
// ---------------------------------------------------------------
`define NVM_RD_BIT 0
`define NVM_READ_GATE_BIT 1
`define NVM_WR_BIT 2
`define NVM_WRITE_GATE_BIT 3
`define NVM_CTRL_RESET 4'h0
`define NVM_ADDR_RESET 6'h00
`define NVM_DATA_RESET 8'h00

// ---------------------------------------------------------------
// timing and array depth
// ---------------------------------------------------------------
`define NVM_CLK_PERIOD_NS 25
`define NVM_WRITE_TIME_US 2000
`define NVM_READ_CYCLES 2
`define NVM_DEPTH 64

`endif

// File: shared/nvm_pkg.sv
// types shared by the store access block
package nvm_pkg;

  typedef struct packed {
    logic bank;
    logic [7:0] addr;
    logic we;
    logic re;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
    logic write_enable_gate;
    logic wr;
    logic read_enable_gate;
    logic rd;
    logic [16:0] cnt;
    logic [5:0] lat_addr;
    logic [7:0] lat_data;
    logic [7:0] rdata;
    logic done;
  } ctrl_state_s;

endpackage
